/* rtl/subtract_instruction_unit.sv */
// four-phase execution of the literal and register subtract instructions
`timescale 1ns/100ps
`include "subtract_unit_defines.svh"

module subtract_instruction_unit #(
  parameter int BANK_W = 4,
  parameter int ADDR_W = BANK_W + 8
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          instr_valid,
  input  wire logic [`INSTR_MSB:0]           instr,
  input  wire logic [BANK_W-1:0]             bank_select_reg,
  input  wire logic                          acc_load,
  input  wire logic [7:0]                    acc_load_data,
  input  wire logic [7:0]                    mem_rd_data,
  output logic                               instr_ready,
  output logic                               instr_done,
  output logic                               instr_unsupported,
  output subtract_unit_pkg::phase_type       phase,
  output logic      [ADDR_W-1:0]             mem_addr,
  output logic                               mem_rd_en,
  output logic                               mem_wr_en,
  output logic      [7:0]                    mem_wr_data,
  output logic      [7:0]                    acc,
  output logic                               borrow_not_flag,
  output logic                               nibble_borrow_flag,
  output logic                               result_nil_flag,
  output logic                               signed_wrap_flag,
  output logic                               top_bit_flag
);

  import subtract_unit_pkg::*;

  function automatic logic is_lit_op(input logic [`INSTR_MSB:0] word);
    is_lit_op = (word[`INSTR_MSB:`LIT_OPC_LSB] == `LIT_SUB_OPCODE);
  endfunction

  function automatic logic is_reg_op(input logic [`INSTR_MSB:0] word);
    is_reg_op = (word[`INSTR_MSB:`REG_OPC_LSB] == `REG_SUB_OPCODE);
  endfunction

  // reset release
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // phase sequencer: runs every clock, one phase per cycle
  phase_type   next_phase;
  op_kind_type op_kind;
  op_kind_type next_op_kind;

  always_comb begin
    unique case (phase)
      phase_decode:  next_phase = phase_read;
      phase_read:    next_phase = phase_process;
      phase_process: next_phase = phase_write;
      phase_write:   next_phase = phase_decode;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      phase <= phase_decode;
    end else begin
      phase <= next_phase;
    end
  end

  // decode
  logic                  take_instr;
  logic                  dec_lit;
  logic                  dec_reg;
  logic [BANK_W-1:0]     next_bank;
  logic [`INSTR_MSB:0]   instr_reg;

  assign instr_ready  = (phase == phase_decode);
  assign take_instr   = instr_ready && instr_valid;
  assign dec_lit      = take_instr && is_lit_op(instr);
  assign dec_reg      = take_instr && is_reg_op(instr);
  assign next_op_kind = dec_lit ? op_literal : (dec_reg ? op_register : op_none);
  // bank bit clear ignores the bank select value entirely
  assign next_bank    = instr[`BANK_BIT] ? bank_select_reg : `ACCESS_BANK;

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      op_kind   <= op_none;
      instr_reg <= '0;
      mem_addr  <= '0;
    end else if (phase == phase_decode) begin
      op_kind   <= next_op_kind;
      instr_reg <= instr;
      if (dec_reg) begin
        mem_addr <= {next_bank, instr[`OPND_MSB:0]};
      end
    end
  end

  // unsupported words still consume a full instruction slot
  logic instr_reg_taken;

  assign instr_unsupported = (phase == phase_read) && (op_kind == op_none)
                           && instr_reg_taken;

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      instr_reg_taken <= 1'b0;
    end else if (phase == phase_decode) begin
      instr_reg_taken <= take_instr;
    end
  end

  // read: latch the literal, or request the file register
  logic [7:0] literal;
  logic [7:0] operand_in;

  assign mem_rd_en = (phase == phase_read) && (op_kind == op_register);

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      literal <= `DATA_RESET;
    end else if (phase == phase_read && op_kind == op_literal) begin
      literal <= instr_reg[`OPND_MSB:0];
    end
  end

  // memory answers one cycle after the read request, i.e. during process
  assign operand_in = (op_kind == op_literal) ? literal : mem_rd_data;

  // process
  logic [7:0] alu_diff;
  logic       alu_borrow_not;
  logic       alu_nibble;
  logic       alu_wrap;
  logic       alu_zero;
  logic       alu_top;

  subtract_core #(
    .DATA_W (8)
  ) u_core (
    .minuend           (operand_in),
    .subtrahend        (acc),
    .diff              (alu_diff),
    .borrow_not        (alu_borrow_not),
    .nibble_borrow_not (alu_nibble),
    .signed_wrap       (alu_wrap),
    .zero              (alu_zero),
    .top_bit           (alu_top)
  );

  logic stage_borrow_not;
  logic stage_nibble;
  logic stage_wrap;
  logic stage_zero;
  logic stage_top;

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      mem_wr_data      <= `DATA_RESET;
      stage_borrow_not <= `FLAG_RESET;
      stage_nibble     <= `FLAG_RESET;
      stage_wrap       <= `FLAG_RESET;
      stage_zero       <= `FLAG_RESET;
      stage_top        <= `FLAG_RESET;
    end else if (phase == phase_process && op_kind != op_none) begin
      mem_wr_data      <= alu_diff;
      stage_borrow_not <= alu_borrow_not;
      stage_nibble     <= alu_nibble;
      stage_wrap       <= alu_wrap;
      stage_zero       <= alu_zero;
      stage_top        <= alu_top;
    end
  end

  // write: destination and flags commit together
  logic commit;
  logic acc_dest;

  assign commit     = (phase == phase_write) && (op_kind != op_none);
  assign instr_done = commit;
  assign acc_dest   = (op_kind == op_literal)
                    || (op_kind == op_register && !instr_reg[`DEST_BIT]);
  assign mem_wr_en  = (phase == phase_write) && (op_kind == op_register)
                    && instr_reg[`DEST_BIT];

  // an instruction write beats a simultaneous external load
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      acc <= `ACC_RESET;
    end else if (commit && acc_dest) begin
      acc <= mem_wr_data;
    end else if (acc_load) begin
      acc <= acc_load_data;
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      borrow_not_flag    <= `FLAG_RESET;
      nibble_borrow_flag <= `FLAG_RESET;
      result_nil_flag    <= `FLAG_RESET;
      signed_wrap_flag   <= `FLAG_RESET;
      top_bit_flag       <= `FLAG_RESET;
    end else if (commit) begin
      borrow_not_flag    <= stage_borrow_not;
      nibble_borrow_flag <= stage_nibble;
      result_nil_flag    <= stage_zero;
      signed_wrap_flag   <= stage_wrap;
      top_bit_flag       <= stage_top;
    end
  end

  // checks
  a_lit_result:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (phase == phase_process && op_kind == op_literal)
      |-> ##2 (acc == 8'($past(literal, 2) - $past(acc, 2))))
    else $error("literal subtract wrote a wrong accumulator");

  a_lit_phases:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (take_instr && is_lit_op(instr))
      |-> ##1 (!mem_rd_en && !mem_wr_en) ##2 (instr_done && phase == phase_write))
    else $error("literal subtract phases out of order");

  a_reg_result:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (phase == phase_process && op_kind == op_register)
      |=> (mem_wr_data == 8'($past(mem_rd_data) - $past(acc))))
    else $error("register subtract result wrong");

  a_dest_select:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (commit && op_kind == op_register && !acc_load)
      |-> (mem_wr_en == instr_reg[`DEST_BIT])
          ##1 (acc == (instr_reg[`DEST_BIT] ? $past(acc) : $past(mem_wr_data))))
    else $error("register subtract destination wrong");

  a_bank_address:
    assert property (@(posedge clk) disable iff (!rst_sync)
      dec_reg |=> (mem_addr == ($past(instr[`BANK_BIT])
                   ? {$past(bank_select_reg), $past(instr[`OPND_MSB:0])}
                   : {`ACCESS_BANK, $past(instr[`OPND_MSB:0])})))
    else $error("file register address wrong");

  a_reg_phases:
    assert property (@(posedge clk) disable iff (!rst_sync)
      dec_reg |=> (mem_rd_en && !mem_wr_en) ##1 (!mem_rd_en && !mem_wr_en)
                  ##1 (instr_done && !mem_rd_en))
    else $error("register subtract phases out of order");

  a_borrow_flag:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (phase == phase_process && op_kind != op_none)
      |-> ##2 (borrow_not_flag == ($past(operand_in, 2) >= $past(acc, 2))))
    else $error("borrow flag wrong");

  a_negative_flags:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (commit && !stage_borrow_not)
      |=> (!borrow_not_flag && top_bit_flag == $past(mem_wr_data[`TOP_BIT])))
    else $error("borrow case flags wrong");

  a_zero_flags:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (commit && mem_wr_data == `ZERO_BYTE)
      |=> (result_nil_flag && borrow_not_flag && !top_bit_flag))
    else $error("zero result flags wrong");

  a_wrap_result:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (phase == phase_process && op_kind != op_none && operand_in < acc)
      |=> (mem_wr_data == 8'({1'b1, $past(operand_in)} - {1'b0, $past(acc)})))
    else $error("borrowing result not wrapped");

  a_nibble_flag:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (phase == phase_process && op_kind != op_none)
      |-> ##2 (nibble_borrow_flag == ($past(operand_in[`NIBBLE_MSB:0], 2)
                                      >= $past(acc[`NIBBLE_MSB:0], 2))))
    else $error("nibble borrow flag wrong");

  a_top_bit:
    assert property (@(posedge clk) disable iff (!rst_sync)
      commit |=> (top_bit_flag == $past(mem_wr_data[`TOP_BIT])))
    else $error("top bit flag wrong");

  a_flags_hold:
    assert property (@(posedge clk) disable iff (!rst_sync)
      (!commit) |=> $stable(result_nil_flag) && $stable(borrow_not_flag))
    else $error("flags moved without an instruction");

endmodule

/* rtl/subtract_unit_defines.svh */
// constants for the subtract instruction unit
`ifndef SUBTRACT_UNIT_DEFINES_SVH
`define SUBTRACT_UNIT_DEFINES_SVH

`define INSTR_MSB       15
`define LIT_OPC_LSB     8
`define LIT_SUB_OPCODE  8'h08
`define REG_OPC_LSB     10
`define REG_SUB_OPCODE  6'h17
`define DEST_BIT        9
`define BANK_BIT        8
`define OPND_MSB        7
`define NIBBLE_MSB      3
`define TOP_BIT         7
`define ACCESS_BANK     4'h0
`define ACC_RESET       8'h00
`define DATA_RESET      8'h00
`define ZERO_BYTE       8'h00
`define FLAG_RESET      1'b0

`endif

/* rtl/subtract_unit_pkg.sv */
// types shared by the subtract instruction unit
package subtract_unit_pkg;

  typedef enum logic [1:0] {
    phase_decode,
    phase_read,
    phase_process,
    phase_write
  } phase_type;

  typedef enum logic [1:0] {
    op_none,
    op_literal,
    op_register
  } op_kind_type;

endpackage

/* rtl/subtract_core.sv */
// 8-bit two's complement subtractor with status outputs
`timescale 1ns/100ps
`include "subtract_unit_defines.svh"

module subtract_core #(
  parameter int DATA_W = 8
) (
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  output logic      [DATA_W-1:0] diff,
  output logic                   borrow_not,
  output logic                   nibble_borrow_not,
  output logic                   signed_wrap,
  output logic                   zero,
  output logic                   top_bit
);

  logic [DATA_W:0]        full_sum;
  logic [`NIBBLE_MSB+1:0] nib_sum;

  // minuend plus inverted subtrahend plus one: carry out means no borrow
  assign full_sum          = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, 1'b1};
  assign nib_sum           = {1'b0, minuend[`NIBBLE_MSB:0]}
                           + {1'b0, ~subtrahend[`NIBBLE_MSB:0]}
                           + {{(`NIBBLE_MSB+1){1'b0}}, 1'b1};
  assign diff              = full_sum[DATA_W-1:0];
  assign borrow_not        = full_sum[DATA_W];
  assign nibble_borrow_not = nib_sum[`NIBBLE_MSB+1];
  // operands of unlike sign and a result whose sign differs from the minuend
  assign signed_wrap       = (minuend[DATA_W-1] != subtrahend[DATA_W-1])
                           && (diff[DATA_W-1] != minuend[DATA_W-1]);
  assign zero              = (diff == {DATA_W{1'b0}});
  assign top_bit           = diff[DATA_W-1];

endmodule

/* testbench/subtract_instruction_unit_tb.sv */
// self-checking bench for the four-phase subtract instruction unit
`timescale 1ns/100ps

module subtract_instruction_unit_tb;
  import subtract_unit_pkg::*;

  logic              clk;
  logic              rst_n;
  logic              instr_valid;
  logic [15:0]       instr;
  logic [3:0]        bank_select_reg;
  logic              acc_load;
  logic [7:0]        acc_load_data;
  logic [7:0]        mem_rd_data;
  logic              instr_ready;
  logic              instr_done;
  logic              instr_unsupported;
  phase_type         phase;
  logic [11:0]       mem_addr;
  logic              mem_rd_en;
  logic              mem_wr_en;
  logic [7:0]        mem_wr_data;
  logic [7:0]        acc;
  logic              borrow_not_flag;
  logic              nibble_borrow_flag;
  logic              result_nil_flag;
  logic              signed_wrap_flag;
  logic              top_bit_flag;
  logic [7:0]        mem [0:4095];
  logic [4:0]        ef;
  int                miscompares;
  int                checked;

  subtract_instruction_unit u_dut (
    .clk               (clk),
    .rst_n             (rst_n),
    .instr_valid       (instr_valid),
    .instr             (instr),
    .bank_select_reg   (bank_select_reg),
    .acc_load          (acc_load),
    .acc_load_data     (acc_load_data),
    .mem_rd_data       (mem_rd_data),
    .instr_ready       (instr_ready),
    .instr_done        (instr_done),
    .instr_unsupported (instr_unsupported),
    .phase             (phase),
    .mem_addr          (mem_addr),
    .mem_rd_en         (mem_rd_en),
    .mem_wr_en         (mem_wr_en),
    .mem_wr_data       (mem_wr_data),
    .acc               (acc),
    .borrow_not_flag   (borrow_not_flag),
    .nibble_borrow_flag(nibble_borrow_flag),
    .result_nil_flag   (result_nil_flag),
    .signed_wrap_flag  (signed_wrap_flag),
    .top_bit_flag      (top_bit_flag)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // file register model; outside the process phase the data line shows the
  // inverse, so a design sampling in the wrong phase sees wrong data
  always @(negedge clk) begin
    mem_rd_data <= (phase === phase_process) ? mem[mem_addr] : ~mem[mem_addr];
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_val({15'h0, got}, {15'h0, exp});
  endtask

  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // returns borrow_not, nibble no-borrow, signed overflow, result
  function automatic logic [10:0] model(input logic [7:0] m, input logic [7:0] w);
    logic [7:0] d;
    d = m - w;
    return {m >= w, m[3:0] >= w[3:0], (m[7] ^ w[7]) & (d[7] ^ m[7]), d};
  endfunction

  task automatic run_op(input logic [15:0] word, input logic [7:0] w0, input logic [7:0] mv,
                        input logic [3:0] bank, input logic clash);
    logic        lit;
    logic        rg;
    logic        sup;
    logic [11:0] ad;
    logic [10:0] res;
    logic [7:0]  ea;
    int          n;
    lit = (word[15:8] == 8'h08);
    rg = (word[15:10] == 6'h17);
    sup = lit | rg;
    ad = word[8] ? {bank, word[7:0]} : {4'h0, word[7:0]};
    if (rg) mem[ad] = mv;
    res = model(rg ? mv : word[7:0], w0);
    // one edge apart from the previous call's load release
    @(negedge clk);
    acc_load = 1'b1;
    acc_load_data = w0;
    @(negedge clk);
    acc_load = 1'b0;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check_flag(instr_ready, 1'b1);
    instr_valid = 1'b1;
    instr = word;
    bank_select_reg = bank;
    @(negedge clk);
    // later changes must not leak into the taken instruction
    instr_valid = 1'b0;
    instr = ~word;
    bank_select_reg = ~bank;
    check_val({14'h0, phase}, {14'h0, phase_read});
    check_flag(mem_rd_en, rg);
    check_flag(instr_unsupported, ~sup);
    if (rg) check_val({4'h0, mem_addr}, {4'h0, ad});
    @(negedge clk);
    check_val({14'h0, phase}, {14'h0, phase_process});
    @(negedge clk);
    check_val({14'h0, phase}, {14'h0, phase_write});
    check_flag(instr_done, sup);
    check_flag(mem_wr_en, rg & word[9]);
    // file register takes the design's write strobe and data
    if (mem_wr_en === 1'b1) mem[mem_addr] = mem_wr_data;
    if (clash) begin
      acc_load = 1'b1;
      acc_load_data = ~res[7:0];
    end
    @(negedge clk);
    acc_load = 1'b0;
    ea = (lit | (rg & ~word[9])) ? res[7:0] : w0;
    // unsupported words keep the flags of the last subtract
    if (sup) ef = {res[10:8], res[7:0] == 8'h00, res[7]};
    check_val({8'h0, acc}, {8'h0, ea});
    if (rg) check_val({8'h0, mem[ad]}, {8'h0, word[9] ? res[7:0] : mv});
    check_flag(borrow_not_flag, ef[4]);
    check_val({14'h0, nibble_borrow_flag, signed_wrap_flag}, {14'h0, ef[3:2]});
    check_flag(result_nil_flag, ef[1]);
    check_flag(top_bit_flag, ef[0]);
  endtask

  logic [15:0] words [10];
  logic [7:0]  accs  [10];
  logic [7:0]  mvals [10];

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    bank_select_reg = 4'h0;
    acc_load = 1'b0;
    acc_load_data = 8'h00;
    miscompares = 0;
    checked = 0;
    ef = 5'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    // literal cases, register cases, write-phase clash, unsupported word
    words = '{16'h0802, 16'h0802, 16'h0802, 16'h0880, 16'h0801,
              16'h5e20, 16'h5c20, 16'h5f20, 16'h0810, 16'hffff};
    accs  = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h90, 8'h02, 8'h02, 8'h02, 8'h01, 8'h33};
    mvals = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h01, 8'h00, 8'h00};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check_val({8'h0, acc}, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      // instruction write must win over a same-edge accumulator load
      run_op(words[i], accs[i], mvals[i], 4'h5, i == 8);
      $display("test %0d done", i);
    end
    give_verdict();
  end

  initial begin
    #4000;
    miscompares++;
    $display("watchdog expired");
    give_verdict();
  end

endmodule
